// ---- rtl/ccsr_alu.sv ----
// Flag unit: arithmetic results and carry, half-carry and overflow updates
`timescale 1ns/100ps
module ccsr_alu (
  ccsr_alu_if.alu a
);
  wire       use_cin = (a.op == ccsr_pkg::CCSR_OP_ADDC) || (a.op == ccsr_pkg::CCSR_OP_SUBB);
  wire       cin     = use_cin & a.cy_in;
  wire [8:0] add9    = {1'b0, a.acc} + {1'b0, a.arg2} + {8'h00, cin};
  wire [4:0] add5    = {1'b0, a.acc[3:0]} + {1'b0, a.arg2[3:0]} + {4'h0, cin};
  wire [7:0] add8    = {1'b0, a.acc[6:0]} + {1'b0, a.arg2[6:0]} + {7'h00, cin};
  wire [8:0] sub9    = {1'b0, a.acc} - {1'b0, a.arg2} - {8'h00, cin};
  wire [4:0] sub5    = {1'b0, a.acc[3:0]} - {1'b0, a.arg2[3:0]} - {4'h0, cin};
  wire [7:0] sub8    = {1'b0, a.acc[6:0]} - {1'b0, a.arg2[6:0]} - {7'h00, cin};
  wire [15:0] prod   = a.acc * a.b;
  wire       div_zero = (a.b == 8'h00);
  wire [7:0] quot    = div_zero ? 8'h00 : a.acc / a.b;
  wire [7:0] rmdr    = div_zero ? 8'h00 : a.acc % a.b;
  // Decimal adjust, low nibble then high nibble
  wire       lo_fix  = (a.acc[3:0] > ccsr_pkg::DA_NIB_LIMIT) | a.ac_in;
  wire [8:0] da1     = {1'b0, a.acc} + (lo_fix ? ccsr_pkg::DA_LO_ADJ : 9'h000);
  wire       hi_fix  = da1[8] | a.cy_in | (da1[7:4] > ccsr_pkg::DA_NIB_LIMIT);
  wire [8:0] da2     = {1'b0, da1[7:0]} + (hi_fix ? ccsr_pkg::DA_HI_ADJ : 9'h000);
  wire       bitv    = a.arg2[0];

  always_comb begin
    a.res_acc = a.acc;
    a.res_b   = a.b;
    a.wr_acc  = 1'b0;
    a.wr_b    = 1'b0;
    a.cy      = a.cy_in;
    a.ac      = a.ac_in;
    a.ov      = 1'b0;
    a.upd_cy  = 1'b1;
    a.upd_ac  = 1'b0;
    a.upd_ov  = 1'b0;
    unique case (a.op)
      ccsr_pkg::CCSR_OP_ADD, ccsr_pkg::CCSR_OP_ADDC: begin
        a.res_acc = add9[7:0];
        a.wr_acc  = 1'b1;
        a.cy      = add9[8];
        a.ac      = add5[4];
        a.ov      = add9[8] ^ add8[7];
        a.upd_ac  = 1'b1;
        a.upd_ov  = 1'b1;
      end
      ccsr_pkg::CCSR_OP_SUBB: begin
        a.res_acc = sub9[7:0];
        a.wr_acc  = 1'b1;
        a.cy      = sub9[8];
        a.ac      = sub5[4];
        a.ov      = sub9[8] ^ sub8[7];
        a.upd_ac  = 1'b1;
        a.upd_ov  = 1'b1;
      end
      ccsr_pkg::CCSR_OP_MUL: begin
        a.res_acc = prod[7:0];
        a.res_b   = prod[15:8];
        a.wr_acc  = 1'b1;
        a.wr_b    = 1'b1;
        a.cy      = 1'b0;
        a.ov      = |prod[15:8];
        a.upd_ov  = 1'b1;
      end
      ccsr_pkg::CCSR_OP_DIV: begin
        a.res_acc = quot;
        a.res_b   = rmdr;
        a.wr_acc  = ~div_zero;
        a.wr_b    = ~div_zero;
        a.cy      = 1'b0;
        a.ov      = div_zero;
        a.upd_ov  = 1'b1;
      end
      ccsr_pkg::CCSR_OP_DA: begin
        a.res_acc = da2[7:0];
        a.wr_acc  = 1'b1;
        a.cy      = a.cy_in | da1[8] | da2[8];
      end
      ccsr_pkg::CCSR_OP_CJNE:   a.cy = (a.arg1 < a.arg2);
      ccsr_pkg::CCSR_OP_CLR_C:  a.cy = 1'b0;
      ccsr_pkg::CCSR_OP_SET_C:  a.cy = 1'b1;
      ccsr_pkg::CCSR_OP_CPL_C:  a.cy = ~a.cy_in;
      ccsr_pkg::CCSR_OP_AND_C:  a.cy = a.cy_in & bitv;
      ccsr_pkg::CCSR_OP_AND_NC: a.cy = a.cy_in & ~bitv;
      ccsr_pkg::CCSR_OP_OR_C:   a.cy = a.cy_in | bitv;
      ccsr_pkg::CCSR_OP_OR_NC:  a.cy = a.cy_in | ~bitv;
      ccsr_pkg::CCSR_OP_MOVE_C: a.cy = bitv;
      ccsr_pkg::CCSR_OP_RRC: begin
        a.res_acc = {a.cy_in, a.acc[7:1]};
        a.wr_acc  = 1'b1;
        a.cy      = a.acc[0];
      end
      ccsr_pkg::CCSR_OP_RLC: begin
        a.res_acc = {a.acc[6:0], a.cy_in};
        a.wr_acc  = 1'b1;
        a.cy      = a.acc[7];
      end
      default: a.upd_cy = 1'b0;
    endcase
  end
endmodule : ccsr_alu

// ---- rtl/ccsr_alu_if.sv ----
// Interface: operands and flag results between the register file and its flag unit
`timescale 1ns/100ps
interface ccsr_alu_if;
  ccsr_pkg::ccsr_op_type op;
  logic [7:0]            acc;
  logic [7:0]            b;
  logic [7:0]            arg1;
  logic [7:0]            arg2;
  logic                  cy_in;
  logic                  ac_in;
  logic [7:0]            res_acc;
  logic [7:0]            res_b;
  logic                  wr_acc;
  logic                  wr_b;
  logic                  cy;
  logic                  ac;
  logic                  ov;
  logic                  upd_cy;
  logic                  upd_ac;
  logic                  upd_ov;
  modport core (output op, acc, b, arg1, arg2, cy_in, ac_in,
                input res_acc, res_b, wr_acc, wr_b, cy, ac, ov, upd_cy, upd_ac, upd_ov);
  modport alu  (input op, acc, b, arg1, arg2, cy_in, ac_in,
                output res_acc, res_b, wr_acc, wr_b, cy, ac, ov, upd_cy, upd_ac, upd_ov);
endinterface : ccsr_alu_if

// ---- rtl/ccsr_core_regs.sv ----
// Core working registers: working byte, helper byte, stack pointer, data pointer, status word
//
// How it works
// - Stack pointer resets to 07H; first push lands at 08H.
// - Push increments the stack pointer, then writes at the new address.
// - Low and high pointer bytes form one 16-bit pointer, low in 7:0.
// - Add and subtract set carry on carry out or borrow into bit 7.
// - Multiply and divide always clear carry.
// - Compare-and-jump sets carry when first operand is below the second.
// - Decimal adjust sets carry when the packed sum exceeded 99.
// - Half-carry follows carry out of or borrow into bit 3.
// - Status bit 5 is a user flag only software changes.
// - Bank bits 4:3 place R0-R7 at 00H, 08H, 10H or 18H.
// - Helper byte is second operand and result of multiply and divide.
// - Working, helper and status bytes accept single-bit reads and writes.
// - Protected registers accept software writes only while unlocked; push, pop, pointer increment and instruction results bypass the lock.
// - Add overflow is set when exactly one of bits 6, 7 carries out.
// - Status bit 0 always shows odd parity of the working byte.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps
module ccsr_core_regs #(
  parameter logic [5:0] PROT_MASK = 6'h00
) (
  input  wire logic                  mclk,
  input  wire logic                  rstn,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic [7:0]                 reg_rdata,
  input  wire logic [7:0]            bit_addr,
  input  wire logic                  bit_wr,
  input  wire logic                  bit_wval,
  input  wire logic                  bit_rd,
  output logic                       bit_rdata,
  input  wire logic                  timed_access_guard,
  input  wire logic                  op_valid,
  input  wire ccsr_pkg::ccsr_op_type op_code,
  input  wire logic [7:0]            op_arg1,
  input  wire logic [7:0]            op_arg2,
  input  wire logic                  push_valid,
  input  wire logic [7:0]            push_data,
  input  wire logic                  pop_valid,
  input  wire logic                  data_pointer_word_inc,
  input  wire logic [2:0]            rn_sel,
  output logic [7:0]                 rn_addr,
  output logic                       stk_we,
  output logic                       stk_re,
  output logic [7:0]                 stk_addr,
  output logic [7:0]                 stk_wdata,
  output logic [15:0]                data_pointer_word,
  output logic [7:0]                 main_working_reg,
  output logic [7:0]                 aux_operand_reg,
  output logic [7:0]                 status_word
);

  // One-hot register select from a byte address
  function automatic logic [5:0] sel_of(input logic [7:0] a);
    sel_of = '0;
    sel_of[ccsr_pkg::IDX_SP]  = (a == ccsr_pkg::SP_ADDR);
    sel_of[ccsr_pkg::IDX_DPL] = (a == ccsr_pkg::DPL_ADDR);
    sel_of[ccsr_pkg::IDX_DPH] = (a == ccsr_pkg::DPH_ADDR);
    sel_of[ccsr_pkg::IDX_PSW] = (a == ccsr_pkg::PSW_ADDR);
    sel_of[ccsr_pkg::IDX_ACC] = (a == ccsr_pkg::ACC_ADDR);
    sel_of[ccsr_pkg::IDX_B]   = (a == ccsr_pkg::B_ADDR);
  endfunction : sel_of

  // Selected byte, zero when nothing is selected
  function automatic logic [7:0] mux_of(input logic [5:0] sel,
                                        input logic [ccsr_pkg::NREG-1:0][7:0] v);
    mux_of = 8'h00;
    for (int i = 0; i < ccsr_pkg::NREG; i++) begin
      mux_of = mux_of | (v[i] & {8{sel[i]}});
    end
  endfunction : mux_of

  logic [7:0] sp_q;
  logic [7:0] sp_d;
  logic [7:0] dpl_q;
  logic [7:0] dpl_d;
  logic [7:0] dph_q;
  logic [7:0] dph_d;
  logic [7:1] psw_q;
  logic [7:1] psw_d;
  logic [7:0] acc_q;
  logic [7:0] acc_d;
  logic [7:0] b_q;
  logic [7:0] b_d;
  logic       stk_we_q;
  logic       stk_re_q;
  logic [7:0] stk_addr_q;
  logic [7:0] stk_wdata_q;
  logic [7:0] rdata_q;
  logic       bit_rdata_q;

  ccsr_alu_if alu_bus ();

  ccsr_alu u_alu (
    .a (alu_bus.alu)
  );

  // Live view of every register, parity computed from the working byte
  wire                                parity = ^acc_q;
  wire [7:0]                          psw_view = {psw_q, parity};
  logic [ccsr_pkg::NREG-1:0][7:0]     cur;
  logic [ccsr_pkg::NREG-1:0][7:0]     sw_val;

  assign cur[ccsr_pkg::IDX_SP]  = sp_q;
  assign cur[ccsr_pkg::IDX_DPL] = dpl_q;
  assign cur[ccsr_pkg::IDX_DPH] = dph_q;
  assign cur[ccsr_pkg::IDX_PSW] = psw_view;
  assign cur[ccsr_pkg::IDX_ACC] = acc_q;
  assign cur[ccsr_pkg::IDX_B]   = b_q;

  // Software write decode
  wire [7:0] bit_byte = bit_addr & ccsr_pkg::BIT_BYTE_MASK;
  wire [2:0] bit_idx  = bit_addr[2:0];
  wire [5:0] bit_map  = sel_of(bit_byte) & ccsr_pkg::BITABLE_MASK;
  wire [5:0] wr_ok    = timed_access_guard ? 6'h3F : ~PROT_MASK;
  wire [5:0] byte_we  = (reg_wr ? sel_of(reg_addr) : 6'h00) & wr_ok;
  wire [5:0] bit_we   = (bit_wr ? bit_map : 6'h00) & wr_ok;
  wire [7:0] bit_one  = 8'h01 << bit_idx;

  // Byte write replaces, bit write patches one position
  for (genvar i = 0; i < ccsr_pkg::NREG; i++) begin : g_sw
    assign sw_val[i] = byte_we[i] ? reg_wdata :
                       bit_we[i]  ? ((cur[i] & ~bit_one) | (bit_wval ? bit_one : 8'h00)) :
                                    cur[i];
  end

  // Flag unit operands
  assign alu_bus.op    = op_code;
  assign alu_bus.acc   = acc_q;
  assign alu_bus.b     = b_q;
  assign alu_bus.arg1  = op_arg1;
  assign alu_bus.arg2  = op_arg2;
  assign alu_bus.cy_in = psw_q[ccsr_pkg::CY_POS];
  assign alu_bus.ac_in = psw_q[ccsr_pkg::AC_POS];

  wire       do_acc = op_valid & alu_bus.wr_acc;
  wire       do_b   = op_valid & alu_bus.wr_b;
  wire       do_cy  = op_valid & alu_bus.upd_cy;
  wire       do_ac  = op_valid & alu_bus.upd_ac;
  wire       do_ov  = op_valid & alu_bus.upd_ov;
  wire [7:0] sw_psw = sw_val[ccsr_pkg::IDX_PSW];

  assign acc_d = do_acc ? alu_bus.res_acc : sw_val[ccsr_pkg::IDX_ACC];
  assign b_d   = do_b ? alu_bus.res_b : sw_val[ccsr_pkg::IDX_B];

  // Stored flags: software value, then instruction results on the flags they own
  assign psw_d[ccsr_pkg::CY_POS]  = do_cy ? alu_bus.cy : sw_psw[ccsr_pkg::CY_POS];
  assign psw_d[ccsr_pkg::AC_POS]  = do_ac ? alu_bus.ac : sw_psw[ccsr_pkg::AC_POS];
  assign psw_d[ccsr_pkg::F0_POS]  = sw_psw[ccsr_pkg::F0_POS];
  assign psw_d[ccsr_pkg::RS1_POS] = sw_psw[ccsr_pkg::RS1_POS];
  assign psw_d[ccsr_pkg::RS0_POS] = sw_psw[ccsr_pkg::RS0_POS];
  assign psw_d[ccsr_pkg::OV_POS]  = do_ov ? alu_bus.ov : sw_psw[ccsr_pkg::OV_POS];
  assign psw_d[1]                 = sw_psw[1];

  // Stack pointer: push increments first, pop reads then decrements
  wire [7:0] sp_inc = sp_q + 8'h01;
  wire [7:0] sp_dec = sp_q - 8'h01;
  wire       do_pop = pop_valid & ~push_valid;

  assign sp_d = push_valid ? sp_inc :
                do_pop     ? sp_dec :
                             sw_val[ccsr_pkg::IDX_SP];

  // Data pointer increment carries from low byte into high byte
  wire [15:0] data_pointer_word_cur = {dph_q, dpl_q};
  wire [15:0] data_pointer_word_nxt = data_pointer_word_cur + 16'h0001;

  assign dpl_d = data_pointer_word_inc ? data_pointer_word_nxt[7:0] : sw_val[ccsr_pkg::IDX_DPL];
  assign dph_d = data_pointer_word_inc ? data_pointer_word_nxt[15:8] : sw_val[ccsr_pkg::IDX_DPH];

  // Read decode
  wire [7:0] rd_val  = mux_of(sel_of(reg_addr), cur);
  wire [7:0] bit_src = mux_of(bit_map, cur);
  wire       bit_val = bit_src[bit_idx];

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sp_q <= ccsr_pkg::SP_RST;
    end else begin
      sp_q <= sp_d;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dpl_q <= ccsr_pkg::DPL_RST;
      dph_q <= ccsr_pkg::DPH_RST;
    end else begin
      dpl_q <= dpl_d;
      dph_q <= dph_d;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      psw_q <= ccsr_pkg::PSW_RST[7:1];
      acc_q <= ccsr_pkg::ACC_RST;
      b_q   <= ccsr_pkg::B_RST;
    end else begin
      psw_q <= psw_d;
      acc_q <= acc_d;
      b_q   <= b_d;
    end
  end

  // Scratch-pad access issued with the incremented pointer on push, the current pointer on pop
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stk_we_q    <= 1'b0;
      stk_re_q    <= 1'b0;
      stk_addr_q  <= 8'h00;
      stk_wdata_q <= 8'h00;
    end else begin
      stk_we_q    <= push_valid;
      stk_re_q    <= do_pop;
      stk_addr_q  <= push_valid ? sp_inc : sp_q;
      stk_wdata_q <= push_data;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata_q     <= 8'h00;
      bit_rdata_q <= 1'b0;
    end else begin
      rdata_q     <= reg_rd ? rd_val : 8'h00;
      bit_rdata_q <= bit_rd & bit_val;
    end
  end

  // Working register of the current bank
  assign rn_addr = {3'b000, psw_q[ccsr_pkg::RS1_POS], psw_q[ccsr_pkg::RS0_POS], rn_sel};

  assign reg_rdata         = rdata_q;
  assign bit_rdata         = bit_rdata_q;
  assign stk_we            = stk_we_q;
  assign stk_re            = stk_re_q;
  assign stk_addr          = stk_addr_q;
  assign stk_wdata         = stk_wdata_q;
  assign data_pointer_word = data_pointer_word_cur;
  assign main_working_reg  = acc_q;
  assign aux_operand_reg   = b_q;
  assign status_word       = psw_view;

endmodule : ccsr_core_regs

// ---- rtl/ccsr_pkg.sv ----
// Package: offsets, reset values, flag positions and operation codes of the core registers
package ccsr_pkg;
  localparam logic [7:0] SP_ADDR  = 8'h81;
  localparam logic [7:0] DPL_ADDR = 8'h82;
  localparam logic [7:0] DPH_ADDR = 8'h83;
  localparam logic [7:0] PSW_ADDR = 8'hD0;
  localparam logic [7:0] ACC_ADDR = 8'hE0;
  localparam logic [7:0] B_ADDR   = 8'hF0;

  localparam logic [7:0] SP_RST  = 8'h07;
  localparam logic [7:0] DPL_RST = 8'h00;
  localparam logic [7:0] DPH_RST = 8'h00;
  localparam logic [7:0] PSW_RST = 8'h00;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] B_RST   = 8'h00;

  localparam int NREG    = 6;
  localparam int IDX_SP  = 0;
  localparam int IDX_DPL = 1;
  localparam int IDX_DPH = 2;
  localparam int IDX_PSW = 3;
  localparam int IDX_ACC = 4;
  localparam int IDX_B   = 5;
  localparam logic [5:0] BITABLE_MASK = 6'h38;

  localparam int CY_POS  = 7;
  localparam int AC_POS  = 6;
  localparam int F0_POS  = 5;
  localparam int RS1_POS = 4;
  localparam int RS0_POS = 3;
  localparam int OV_POS  = 2;
  localparam int PAR_POS = 0;

  localparam logic [7:0] BIT_BYTE_MASK = 8'hF8;
  localparam logic [3:0] DA_NIB_LIMIT  = 4'h9;
  localparam logic [8:0] DA_LO_ADJ     = 9'h006;
  localparam logic [8:0] DA_HI_ADJ     = 9'h060;

  typedef enum logic [4:0] {
    CCSR_OP_ADD, CCSR_OP_ADDC, CCSR_OP_SUBB, CCSR_OP_MUL, CCSR_OP_DIV, CCSR_OP_DA,
    CCSR_OP_CJNE, CCSR_OP_CLR_C, CCSR_OP_SET_C, CCSR_OP_CPL_C, CCSR_OP_AND_C,
    CCSR_OP_AND_NC, CCSR_OP_OR_C, CCSR_OP_OR_NC, CCSR_OP_MOVE_C, CCSR_OP_RRC, CCSR_OP_RLC
  } ccsr_op_type;
endpackage : ccsr_pkg

// ---- tb/ccsr_core_regs_props.sv ----
// Checker: port-level properties of the core register block
`timescale 1ns/100ps
module ccsr_core_regs_props #(
  parameter logic [5:0] PROT_MASK = 6'h00
) (
  input wire logic                  mclk,
  input wire logic                  rstn,
  input wire logic [7:0]            reg_addr,
  input wire logic [7:0]            reg_wdata,
  input wire logic                  reg_wr,
  input wire logic                  reg_rd,
  input wire logic [7:0]            reg_rdata,
  input wire logic [7:0]            bit_addr,
  input wire logic                  bit_wr,
  input wire logic                  timed_access_guard,
  input wire logic                  op_valid,
  input wire ccsr_pkg::ccsr_op_type op_code,
  input wire logic [7:0]            op_arg1,
  input wire logic [7:0]            op_arg2,
  input wire logic                  push_valid,
  input wire logic [7:0]            push_data,
  input wire logic                  data_pointer_word_inc,
  input wire logic [2:0]            rn_sel,
  input wire logic [7:0]            rn_addr,
  input wire logic                  stk_we,
  input wire logic [7:0]            stk_addr,
  input wire logic [7:0]            stk_wdata,
  input wire logic [15:0]           data_pointer_word,
  input wire logic [7:0]            main_working_reg,
  input wire logic [7:0]            status_word
);
  logic [8:0] sum9;
  logic [4:0] nib;
  logic [7:0] sum7;
  logic       add_c;
  logic       add_h;
  logic       add_ov;
  assign sum9   = {1'h0, main_working_reg} + {1'h0, op_arg2};
  assign nib    = {1'h0, main_working_reg[3:0]} + {1'h0, op_arg2[3:0]};
  assign sum7   = {1'h0, main_working_reg[6:0]} + {1'h0, op_arg2[6:0]};
  assign add_c  = sum9[8];
  assign add_h  = nib[4];
  assign add_ov = sum9[8] ^ sum7[7];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence s_push_pair;
    push_valid ##1 push_valid;
  endsequence

  a_push_data:
    assert property (push_valid |=> stk_we && stk_wdata == $past(push_data)) else $error("push write missing");
  a_push_incr:
    assert property (s_push_pair |=> stk_we && stk_addr == $past(stk_addr) + 8'h01) else $error("push address not incremented");
  a_ptr_low:
    assert property (reg_wr && reg_addr == ccsr_pkg::DPL_ADDR && !data_pointer_word_inc && (!PROT_MASK[1] || timed_access_guard)
      |=> data_pointer_word[7:0] == $past(reg_wdata)) else $error("pointer low byte not updated");
  a_add_flags:
    assert property (op_valid && op_code == ccsr_pkg::CCSR_OP_ADD
      |=> status_word[7:6] == {$past(add_c), $past(add_h)} && status_word[2] == $past(add_ov)) else $error("add flags wrong");
  a_muldiv_carry:
    assert property (op_valid && (op_code == ccsr_pkg::CCSR_OP_MUL || op_code == ccsr_pkg::CCSR_OP_DIV)
      |=> !status_word[7]) else $error("multiply or divide left carry set");
  a_cmp_carry:
    assert property (op_valid && op_code == ccsr_pkg::CCSR_OP_CJNE
      |=> status_word[7] == ($past(op_arg1) < $past(op_arg2))) else $error("compare carry wrong");
  a_user_flag_hold:
    assert property (!(reg_wr && reg_addr == ccsr_pkg::PSW_ADDR) && !(bit_wr && bit_addr == 8'hD5)
      |=> $stable(status_word[5])) else $error("user flag changed by hardware");
  a_bank_map:
    assert property (rn_addr == {3'h0, status_word[4:3], rn_sel}) else $error("bank address wrong");
  a_parity_bit:
    assert property (status_word[0] == ^main_working_reg) else $error("parity bit wrong");
  a_rdata_idle:
    assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("read data not idle");
endmodule : ccsr_core_regs_props

bind ccsr_core_regs ccsr_core_regs_props #(.PROT_MASK(PROT_MASK)) u_ccsr_core_regs_props (.mclk, .rstn, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .bit_addr, .bit_wr, .timed_access_guard, .op_valid, .op_code, .op_arg1,
  .op_arg2, .push_valid, .push_data, .data_pointer_word_inc, .rn_sel, .rn_addr, .stk_we, .stk_addr, .stk_wdata, .data_pointer_word,
  .main_working_reg, .status_word);

// ---- tb/tb_top.sv ----
// Testbench: register, bit, instruction and stack traffic for the core registers
`timescale 1ns/100ps
module tb_top;
  logic                  mclk, rstn, reg_wr, reg_rd, bit_wr, bit_wval, bit_rd, timed_access_guard;
  logic                  op_valid, push_valid, pop_valid, data_pointer_word_inc, bit_rdata, stk_we, stk_re;
  logic [7:0]            reg_addr, reg_wdata, reg_rdata, bit_addr, op_arg1, op_arg2, push_data;
  logic [7:0]            rn_addr, stk_addr, stk_wdata, main_working_reg, aux_operand_reg, status_word;
  logic [2:0]            rn_sel;
  logic [15:0]           data_pointer_word;
  ccsr_pkg::ccsr_op_type op_code;
  int                    bad_count, n_checks, i;
  logic [7:0]            tab_a [6] = '{8'h81, 8'h82, 8'h83, 8'hD0, 8'hE0, 8'hF0};
  logic [7:0]            cmp_a [3] = '{8'h10, 8'h20, 8'h20};
  logic [7:0]            cmp_b [3] = '{8'h20, 8'h10, 8'h20};
  ccsr_pkg::ccsr_op_type cop [6] = '{ccsr_pkg::CCSR_OP_CPL_C, ccsr_pkg::CCSR_OP_AND_NC, ccsr_pkg::CCSR_OP_OR_NC,
                                    ccsr_pkg::CCSR_OP_AND_C, ccsr_pkg::CCSR_OP_OR_C, ccsr_pkg::CCSR_OP_MOVE_C};
  logic [7:0]            cbit [6] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h01, 8'h00};
  logic                  ccy [6] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0};

  ccsr_core_regs #(.PROT_MASK(6'h01)) u_ccsr_core_regs (.mclk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .bit_addr, .bit_wr, .bit_wval, .bit_rd, .bit_rdata, .timed_access_guard, .op_valid, .op_code,
    .op_arg1, .op_arg2, .push_valid, .push_data, .pop_valid, .data_pointer_word_inc, .rn_sel, .rn_addr, .stk_we, .stk_re,
    .stk_addr, .stk_wdata, .data_pointer_word, .main_working_reg, .aux_operand_reg, .status_word);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'h1;
    @(posedge mclk);
    reg_wr <= 1'h0;
    @(posedge mclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge mclk);
    reg_rd <= 1'h0;
    #1 chk(reg_rdata, exp, what);
    @(posedge mclk);
  endtask : rd

  task automatic bw(input logic [7:0] a, input logic v);
    bit_addr <= a;
    bit_wval <= v;
    bit_wr   <= 1'h1;
    @(posedge mclk);
    bit_wr <= 1'h0;
    @(posedge mclk);
  endtask : bw

  task automatic op(input ccsr_pkg::ccsr_op_type c, input logic [7:0] a1, input logic [7:0] a2);
    op_code  <= c;
    op_arg1  <= a1;
    op_arg2  <= a2;
    op_valid <= 1'h1;
    @(posedge mclk);
    op_valid <= 1'h0;
    @(posedge mclk);
  endtask : op

  task automatic wrap_up;
    if (bad_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  initial begin
    mclk = 1'h0;
    forever #2.5 mclk = ~mclk;
  end

  initial begin
    repeat (3000) @(posedge mclk);
    bad_count++;
    wrap_up();
  end

  initial begin
    {rstn, reg_wr, reg_rd, bit_wr, bit_wval, bit_rd, timed_access_guard} = '0;
    {op_valid, push_valid, pop_valid, data_pointer_word_inc, reg_addr, reg_wdata, bit_addr} = '0;
    {op_arg1, op_arg2, push_data} = '0;
    rn_sel  = 3'h5;
    op_code = ccsr_pkg::CCSR_OP_ADD;
    repeat (10) @(posedge mclk);
    rstn <= 1'h1;
    @(posedge mclk);
    for (i = 0; i < 6; i++) rd(tab_a[i], (i == 0) ? 8'h07 : 8'h00, "reset value");
    wr(8'h85, 8'h5A);
    rd(8'h85, 8'h00, "unmapped");
    // Two pushes back to back, then two pops
    push_data  <= 8'hAA;
    push_valid <= 1'h1;
    @(posedge mclk);
    push_data <= 8'hBB;
    #1 chk({stk_we, stk_addr, stk_wdata}, {1'h1, 8'h08, 8'hAA}, "first push");
    @(posedge mclk);
    push_valid <= 1'h0;
    #1 chk({stk_we, stk_addr, stk_wdata}, {1'h1, 8'h09, 8'hBB}, "second push");
    @(posedge mclk);
    pop_valid <= 1'h1;
    @(posedge mclk);
    #1 chk({stk_re, stk_addr}, {1'h1, 8'h09}, "first pop");
    @(posedge mclk);
    pop_valid <= 1'h0;
    #1 chk({stk_re, stk_addr}, {1'h1, 8'h08}, "second pop");
    @(posedge mclk);
    rd(8'h81, 8'h07, "pointer after pops");
    wr(8'h81, 8'h30);
    rd(8'h81, 8'h07, "locked write");
    timed_access_guard <= 1'h1;
    wr(8'h81, 8'h30);
    timed_access_guard <= 1'h0;
    rd(8'h81, 8'h30, "unlocked write");
    wr(8'h82, 8'hFF);
    wr(8'h83, 8'h12);
    chk(data_pointer_word, 16'h12FF, "pointer word");
    data_pointer_word_inc <= 1'h1;
    @(posedge mclk);
    data_pointer_word_inc <= 1'h0;
    @(posedge mclk);
    chk(data_pointer_word, 16'h1300, "pointer increment");
    wr(8'hE0, 8'h03);
    wr(8'hD0, 8'hFF);
    rd(8'hD0, 8'hFE, "status write keeps parity");
    wr(8'hE0, 8'h07);
    chk(status_word, 8'hFF, "parity follows");
    for (i = 0; i < 4; i++) begin
      wr(8'hD0, 8'(i * 8));
      chk(rn_addr, 8'(i * 8 + 5), "bank address");
    end
    wr(8'hD0, 8'h00);
    wr(8'hE0, 8'h7F);
    op(ccsr_pkg::CCSR_OP_ADD, 8'h00, 8'h01);
    chk({main_working_reg, status_word}, 16'h8045, "add 7F+01");
    op(ccsr_pkg::CCSR_OP_ADD, 8'h00, 8'h80);
    chk({main_working_reg, status_word}, 16'h0084, "add 80+80");
    op(ccsr_pkg::CCSR_OP_SUBB, 8'h00, 8'h01);
    chk({main_working_reg, status_word}, 16'hFEC1, "subtract with borrow");
    wr(8'hE0, 8'h10);
    wr(8'hF0, 8'h10);
    op(ccsr_pkg::CCSR_OP_MUL, 8'h00, 8'h00);
    chk({main_working_reg, aux_operand_reg, status_word[7], status_word[2]}, {16'h0001, 2'h1}, "multiply");
    op(ccsr_pkg::CCSR_OP_SET_C, 8'h00, 8'h00);
    wr(8'hE0, 8'h10);
    wr(8'hF0, 8'h03);
    op(ccsr_pkg::CCSR_OP_DIV, 8'h00, 8'h00);
    chk({main_working_reg, aux_operand_reg, status_word[7]}, {16'h0501, 1'h0}, "divide");
    for (i = 0; i < 3; i++) begin
      op(ccsr_pkg::CCSR_OP_CJNE, cmp_a[i], cmp_b[i]);
      chk(status_word[7], (i == 0) ? 1'h1 : 1'h0, "compare carry");
    end
    wr(8'hD0, 8'h00);
    wr(8'hE0, 8'h56);
    op(ccsr_pkg::CCSR_OP_ADD, 8'h00, 8'h67);
    op(ccsr_pkg::CCSR_OP_DA, 8'h00, 8'h00);
    chk({main_working_reg, status_word[7]}, {8'h23, 1'h1}, "decimal adjust");
    bw(8'hD5, 1'h1);
    op(ccsr_pkg::CCSR_OP_ADD, 8'h00, 8'h01);
    op(ccsr_pkg::CCSR_OP_CLR_C, 8'h00, 8'h00);
    chk(status_word[5], 1'h1, "user flag");
    bit_addr <= 8'hD5;
    bit_rd   <= 1'h1;
    @(posedge mclk);
    bit_rd <= 1'h0;
    #1 chk(bit_rdata, 1'h1, "bit read");
    @(posedge mclk);
    bw(8'hF7, 1'h1);
    chk(aux_operand_reg[7], 1'h1, "bit write helper");
    // Carry-bit operations, each starting from the carry left by the one before
    for (i = 0; i < 6; i++) begin
      op(cop[i], 8'h00, cbit[i]);
      chk(status_word[7], ccy[i], "carry bit op");
    end
    op(ccsr_pkg::CCSR_OP_SET_C, 8'h00, 8'h00);
    op(ccsr_pkg::CCSR_OP_RRC, 8'h00, 8'h00);
    chk({main_working_reg, status_word[7]}, {8'h92, 1'h0}, "rotate right");
    op(ccsr_pkg::CCSR_OP_RLC, 8'h00, 8'h00);
    chk({main_working_reg, status_word[7]}, {8'h24, 1'h1}, "rotate left");
    op(ccsr_pkg::CCSR_OP_ADDC, 8'h00, 8'h5B);
    chk({main_working_reg, status_word}, 16'h8065, "add with carry");
    wr(8'hF0, 8'h00);
    op(ccsr_pkg::CCSR_OP_DIV, 8'h00, 8'h00);
    chk({main_working_reg, aux_operand_reg, status_word[7], status_word[2]}, {16'h8000, 2'h1}, "divide by zero");
    bw(8'hE0, 1'h1);
    chk({main_working_reg, status_word}, 16'h8164, "bit write working");
    // Push and pop together: the pop is refused
    push_valid <= 1'h1;
    pop_valid  <= 1'h1;
    @(posedge mclk);
    {push_valid, pop_valid} <= 2'h0;
    #1 chk({stk_we, stk_re, stk_addr}, {2'h2, 8'h31}, "push beats pop");
    @(posedge mclk);
    wrap_up();
  end
endmodule : tb_top
